// file: design/latched_output_driver.sv
`timescale 1ns/100ps
`default_nettype none

module latched_output_driver #(
	parameter int STAGES = driver_pkg::STAGES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire driver_pkg::pins_t pins,
	input wire logic holdShift,
	output logic bitReady,
	output logic bitDropped,
	output logic serialOut,
	output driver_pkg::drive_t [STAGES-1:0] drive
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam int SD = driver_pkg::SYNC_DEPTH;

	typedef driver_pkg::drive_t [STAGES-1:0] driveVec_t;

	typedef struct packed {
		logic [SD-1:0] dataSync;
		logic [SD-1:0] clkSync;
		logic [SD-1:0] loadSync;
		logic [SD-1:0] blankSync;
		logic dataLevel;
		logic clkLevel;
		logic loadLevel;
		logic blankLevel;
		logic [STAGES-1:0] shift;
		logic [STAGES-1:0] latch;
		driveVec_t drv;
		logic serOut;
		logic dropped;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// first flop only feeds the second; decisions look at second and third
	function automatic logic [SD-1:0] syncStep(input logic [SD-1:0] s, input logic pin);
		return {s[SD-2:0], pin};
	endfunction

	// a level changes only once two late stages agree, filtering one-cycle glitches
	function automatic logic settle(input logic [SD-1:0] s, input logic old);
		return (s[SD-1] == s[SD-2]) ? s[SD-1] : old;
	endfunction

	function automatic driveVec_t outputs(input logic [STAGES-1:0] l, input logic blank);
		driveVec_t v;
		for (int i = 0; i < STAGES; i++) begin
			v[i].source = l[i] && !blank;
			v[i].sink = blank || !l[i];
		end
		return v;
	endfunction

	// ------------------------------------------------------------
	// bit buffer between pin sampling and the shift chain
	// ------------------------------------------------------------
	logic clockRise;
	logic bufInReady;
	logic bufOutValid;
	logic bufOutData;
	logic takeBit;

	two_entry_buffer #(
		.WIDTH(driver_pkg::BUF_WIDTH),
		.DEPTH(driver_pkg::BUF_DEPTH)
	) bitBuffer (
		.clock(clock),
		.nrst(nrst),
		.inValid(clockRise),
		.inData(s_d.dataLevel),
		.inReady(bufInReady),
		.outValid(bufOutValid),
		.outData(bufOutData),
		.outReady(!holdShift)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.dataSync = syncStep(s_q.dataSync, pins.data);
		s_d.clkSync = syncStep(s_q.clkSync, pins.shiftClk);
		s_d.loadSync = syncStep(s_q.loadSync, pins.latchLoad);
		s_d.blankSync = syncStep(s_q.blankSync, pins.blank);
		s_d.dataLevel = settle(s_q.dataSync, s_q.dataLevel);
		s_d.clkLevel = settle(s_q.clkSync, s_q.clkLevel);
		s_d.loadLevel = settle(s_q.loadSync, s_q.loadLevel);
		s_d.blankLevel = settle(s_q.blankSync, s_q.blankLevel);

		// data settles alongside the clock, so setup at the pin carries through
		clockRise = s_d.clkLevel && !s_q.clkLevel;
		s_d.dropped = clockRise && !bufInReady;

		takeBit = bufOutValid && !holdShift;
		if (takeBit) begin
			s_d.shift = {s_q.shift[STAGES-2:0], bufOutData};
		end

		// transparent while load is high, frozen otherwise; blanking is not a term here
		if (s_q.loadLevel) begin
			s_d.latch = s_d.shift;
		end else begin
			s_d.latch = s_q.latch;
		end

		s_d.serOut = s_d.shift[STAGES-1];
		s_d.drv = outputs(s_d.latch, s_d.blankLevel);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q.dataSync <= driver_pkg::SYNC_RESET;
			s_q.clkSync <= driver_pkg::SYNC_RESET;
			s_q.loadSync <= driver_pkg::SYNC_RESET;
			s_q.blankSync <= driver_pkg::SYNC_RESET;
			s_q.dataLevel <= driver_pkg::LEVEL_RESET;
			s_q.clkLevel <= driver_pkg::LEVEL_RESET;
			s_q.loadLevel <= driver_pkg::LEVEL_RESET;
			s_q.blankLevel <= driver_pkg::BLANK_RESET;
			s_q.shift <= driver_pkg::SHIFT_RESET;
			s_q.latch <= driver_pkg::LATCH_RESET;
			s_q.drv <= {STAGES{2'h1}};
			s_q.serOut <= 1'h0;
			s_q.dropped <= 1'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign bitReady = bufInReady;
	assign bitDropped = s_q.dropped;
	assign serialOut = s_q.serOut;
	assign drive = s_q.drv;

endmodule

`default_nettype wire

// file: design/driver_pkg.sv
package driver_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int STAGES = 10;
	localparam int SYNC_DEPTH = 3;
	localparam int BUF_DEPTH = 2;
	localparam int BUF_WIDTH = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [STAGES-1:0] SHIFT_RESET = 10'h000;
	localparam logic [STAGES-1:0] LATCH_RESET = 10'h000;
	localparam logic [SYNC_DEPTH-1:0] SYNC_RESET = 3'h0;
	// blanked in reset, but the zeroed sync flops clear it on the first clock after: outputs stay off through reset
	localparam logic BLANK_RESET = 1'h1;
	localparam logic LEVEL_RESET = 1'h0;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic source;
		logic sink;
	} drive_t;

	typedef struct packed {
		logic data;
		logic shiftClk;
		logic latchLoad;
		logic blank;
	} pins_t;

endpackage

// file: design/two_entry_buffer.sv
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
	parameter int WIDTH = driver_pkg::BUF_WIDTH,
	parameter int DEPTH = driver_pkg::BUF_DEPTH
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);

	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [CW-1:0] count;
		logic [PW-1:0] rd;
		logic ready;
	} bufState_t;

	bufState_t s_q;
	bufState_t s_d;

	function automatic logic [PW-1:0] wrap(input int idx);
		return PW'(idx % DEPTH);
	endfunction

	logic push;
	logic pop;

	always_comb begin
		s_d = s_q;
		pop = (s_q.count != '0) && outReady;
		push = inValid && s_q.ready;
		if (push) begin
			s_d.mem[wrap(int'(s_q.rd) + int'(s_q.count))] = inData;
		end
		if (pop) begin
			s_d.rd = wrap(int'(s_q.rd) + 1);
		end
		case ({push, pop})
			2'b10: s_d.count = s_q.count + CW'(1);
			2'b01: s_d.count = s_q.count - CW'(1);
			default: s_d.count = s_q.count;
		endcase
		// ready is registered so a full buffer refuses in the same cycle it fills
		s_d.ready = (s_d.count != FULL);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{mem: '0, count: '0, rd: '0, ready: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign inReady = s_q.ready;
	assign outValid = (s_q.count != '0);
	assign outData = s_q.mem[s_q.rd];

endmodule

`default_nettype wire

// file: test/driver_props.sv
`timescale 1ns/100ps
`default_nettype none

module driver_props #(
	parameter int STAGES = driver_pkg::STAGES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire driver_pkg::pins_t pins,
	input wire logic holdShift,
	input wire logic bitReady,
	input wire logic bitDropped,
	input wire logic serialOut,
	input wire driver_pkg::drive_t [STAGES-1:0] drive
);
	// ----
	// checks
	// ----
	logic [STAGES-1:0] srcs;
	logic [STAGES-1:0] snks;
	always_comb begin
		for (int i = 0; i < STAGES; i++) begin
			srcs[i] = drive[i].source;
			snks[i] = drive[i].sink;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// pins pass three sync flops, so settled means several cycles
	property p_blankOff; pins.blank [*6] |-> srcs == '0 && snks == '1; endproperty
	a_blankOff: assert property (p_blankOff) else $error("blank left a driver on");
	property p_blankRise; $rose(pins.blank) |-> ##[1:6] srcs == '0; endproperty
	a_blankRise: assert property (p_blankRise) else $error("blank too slow");
	property p_pair; srcs == ~snks; endproperty
	a_pair: assert property (p_pair) else $error("source and sink disagree");
	property p_hold; (!pins.latchLoad && !pins.blank) [*8] |-> $stable(srcs); endproperty
	a_hold: assert property (p_hold) else $error("latch moved with load low");
	property p_follow; (pins.latchLoad && !pins.blank) [*8] |-> srcs[STAGES-1] == serialOut; endproperty
	a_follow: assert property (p_follow) else $error("open latch not following");
	property p_stall; holdShift [*3] |-> $stable(serialOut); endproperty
	a_stall: assert property (p_stall) else $error("chain moved while stalled");
	property p_drop; bitDropped |-> !$past(bitReady) ##1 !bitDropped; endproperty
	a_drop: assert property (p_drop) else $error("bad drop pulse");
	property p_drain; !holdShift [*4] |-> bitReady; endproperty
	a_drain: assert property (p_drain) else $error("buffer not drained");
endmodule

bind latched_output_driver driver_props #(.STAGES(STAGES)) props (.clock(clock), .nrst(nrst),
	.pins(pins), .holdShift(holdShift), .bitReady(bitReady), .bitDropped(bitDropped),
	.serialOut(serialOut), .drive(drive));

`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_model (
	input wire logic clock,
	output var driver_pkg::pins_t pins
);
	initial pins = '0;
	task automatic hold(int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic shiftBit(logic b);
		if (pins.latchLoad) pins.blank = 1'h1;
		pins.data = b;
		hold(4);
		pins.shiftClk = 1'h1;
		hold(4);
		pins.shiftClk = 1'h0;
		hold(4);
		// hold time over: data no longer shows the bit
		pins.data = ~b;
	endtask
endmodule

`default_nettype wire

// file: test/latched_output_driver_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module latched_output_driver_tb_top;
	logic clock = 1'h0;
	logic nrst = 1'h0;
	logic holdShift = 1'h0;
	logic bitReady, bitDropped, serialOut;
	logic dropSeen = 1'h0;
	driver_pkg::pins_t pins;
	driver_pkg::drive_t [9:0] drive;
	int fail_count = 0;
	int samples_checked = 0;
	logic [9:0] sh = '0;
	logic [9:0] lat = '0;
	always #10 clock = ~clock;
	always @(posedge clock) if (bitDropped === 1'h1) dropSeen <= 1'h1;
	host_model host (.clock(clock), .pins(pins));
	latched_output_driver dut (.clock(clock), .nrst(nrst), .pins(pins), .holdShift(holdShift),
		.bitReady(bitReady), .bitDropped(bitDropped), .serialOut(serialOut), .drive(drive));
	// ----
	// helpers
	// ----
	task automatic chk(string n, logic [19:0] e, logic [19:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [19:0] outs(logic [9:0] l, logic b);
		for (int i = 0; i < 10; i++) outs[2*i +: 2] = b ? 2'h1 : {l[i], ~l[i]};
	endfunction
	task automatic send(logic b);
		host.shiftBit(b);
		sh = {sh[8:0], b};
	endtask
	task automatic strobe;
		host.pins.latchLoad = 1'h1;
		host.hold(8);
		host.pins.latchLoad = 1'h0;
		host.hold(8);
		lat = sh;
	endtask
	// ----
	// tests
	// ----
	task automatic t_shift;
		for (int i = 9; i >= 0; i--) send(1'(10'h2b5 >> i));
		chk("held", outs(lat, 1'h0), drive);
		chk("serialOut", {19'h0, sh[9]}, {19'h0, serialOut});
		strobe();
		chk("loaded", outs(10'h2b5, 1'h0), drive);
		$display("shift test done");
	endtask
	task automatic t_blank;
		host.pins.blank = 1'h1;
		host.hold(8);
		chk("blanked", outs(lat, 1'h1), drive);
		host.pins.blank = 1'h0;
		host.hold(8);
		chk("restored", outs(lat, 1'h0), drive);
		$display("blank test done");
	endtask
	task automatic t_open;
		host.pins.latchLoad = 1'h1;
		send(1'h1);
		send(1'h0);
		host.pins.blank = 1'h0;
		host.hold(8);
		chk("open", outs(sh, 1'h0), drive);
		host.pins.latchLoad = 1'h0;
		host.hold(8);
		lat = sh;
		$display("open test done");
	endtask
	task automatic t_stall;
		holdShift = 1'h1;
		send(1'h1);
		send(1'h1);
		chk("bitReady", 20'h0, {19'h0, bitReady});
		host.shiftBit(1'h0);
		chk("dropSeen", 20'h1, {19'h0, dropSeen});
		holdShift = 1'h0;
		host.hold(8);
		strobe();
		chk("after stall", outs(sh, 1'h0), drive);
		$display("stall test done");
	endtask
	task automatic summarize;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		host.hold(5);
		nrst = 1'h1;
		t_shift();
		t_blank();
		t_open();
		t_stall();
		summarize();
	end
	initial begin
		#100us;
		fail_count++;
		summarize();
	end
endmodule

`default_nettype wire
